// file: rtl/tmac_match_ctrl.sv
`timescale 1ns/100ps

// Summary of operation
// - Halt-on-match stops counters, clears run enable
// - Clear-on-match resets the count
// - Irq-on-match raises interrupt, gated by condition select
// - Halt and clear together: only halt
module tmac_match_ctrl
  import tmac_pkg::*;
#(
  parameter int unsigned CNT_W = COUNT_W       // Width of the count and match values
) (
  input  wire logic              mclk,               // Peripheral clock, 100 MHz
  input  wire logic              arst_n,             // Asynchronous reset, active low
  input  wire logic [ADDR_W-1:0] regAddr,            // Register byte address
  input  wire logic [DATA_W-1:0] regWdata,           // Register write data
  input  wire logic              regWr,              // Write strobe, one cycle
  input  wire logic              regRd,              // Read strobe, one cycle
  output logic      [DATA_W-1:0] regRdata,           // Read data, cycle after the strobe
  input  wire logic [CNT_W-1:0]  countValue,         // Running count from the counter core
  input  wire logic [CNT_W-1:0]  matchValue0,        // Match value of channel 0
  input  wire logic [CNT_W-1:0]  matchValue1,        // Match value of channel 1
  input  wire logic [CNT_W-1:0]  matchValue2,        // Match value of channel 2
  input  wire logic              counterRunEnable,   // Counter core is running
  input  wire logic [2:0]        irqConditionSelect, // Interrupt condition select field
  output logic                   haltCounters,       // Pulse: stop count and prescale, clear run enable
  output logic                   clearCount,         // Pulse: reset the count to zero
  output logic      [NUM_CH-1:0] matchFlag,          // Pulse per channel: match seen
  output logic                   irq                 // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Match detection

  logic [CNT_W-1:0]    matchVal [NUM_CH];  // Match values as an array
  logic [NUM_CH-1:0]   hit;                // Channel equals the count while running
  logic [NUM_CH-1:0]   haltEn;             // Halt bits per channel
  logic [NUM_CH-1:0]   clrEn;              // Clear bits per channel
  logic [NUM_CH-1:0]   irqEn;              // Interrupt bits per channel
  logic [ACTION_W-1:0] action;             // Action register
  logic [NUM_CH-1:0]   status;             // Sticky interrupt flags
  logic [NUM_CH-1:0]   mask;               // Interrupt mask
  wire                 condOk;             // Condition select permits match interrupts
  wire  [NUM_CH-1:0]   irqSet;             // Flags to set this cycle
  wire                 anyHalt;            // Some channel asks for a halt
  wire                 anyClear;           // Some channel asks for a clear

  assign matchVal[0] = matchValue0;
  assign matchVal[1] = matchValue1;
  assign matchVal[2] = matchValue2;

  // A stopped counter sits on its last value; only a running one may match
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    assign hit[ch]    = counterRunEnable && (countValue == matchVal[ch]);
    assign haltEn[ch] = action[act_bit(ch, HALT_OFS)];
    assign clrEn[ch]  = action[act_bit(ch, CLR_OFS)];
    assign irqEn[ch]  = action[act_bit(ch, IRQ_OFS)];
  end

  assign condOk   = (irqConditionSelect == COND_ON_MATCH);
  assign irqSet   = hit & irqEn & {NUM_CH{condOk}};
  assign anyHalt  = |(hit & haltEn);
  // Any halt in the same cycle suppresses every clear, so a stopped count stays
  assign anyClear = |(hit & clrEn) && !anyHalt;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire selAction = (regAddr == OFS_ACTION);
  wire selStatus = (regAddr == OFS_STATUS);
  wire selMask   = (regAddr == OFS_MASK);
  wire wrAction  = regWr && selAction;
  wire wrStatus  = regWr && selStatus;
  wire wrMask    = regWr && selMask;

  // Read mux; unmapped offsets read zero, bits above each field read zero
  wire [DATA_W-1:0] rdMux =
      selAction ? DATA_W'(action) :
      selStatus ? DATA_W'(status) :
      selMask   ? DATA_W'(mask)   : '0;

  // Flags: hardware set wins over a write-one clear in the same cycle
  wire [NUM_CH-1:0] next_status = (status & ~(wrStatus ? regWdata[NUM_CH-1:0] : '0)) | irqSet;
  // Mask as it stands after this edge, so a mask write moves irq at once
  wire [NUM_CH-1:0] next_mask   = wrMask ? regWdata[NUM_CH-1:0] : mask;

  ////////////////////////////////////////////////////////////////////////////
  // Action, mask and flag registers

  // Action bits are plain read/write storage, all off after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      action <= ACTION_RST;
    end else if (wrAction) begin
      action <= regWdata[ACTION_W-1:0];
    end
  end

  // Mask register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask <= FLAG_RST;
    end else if (wrMask) begin
      mask <= regWdata[NUM_CH-1:0];
    end
  end

  // Sticky flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status <= FLAG_RST;
    end else begin
      status <= next_status;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? rdMux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Action outputs, registered one cycle after the match

  // Pulses repeat while the count sits on a match value; the core acts once
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      haltCounters <= 1'b0;
      clearCount   <= 1'b0;
      matchFlag    <= '0;
    end else begin
      haltCounters <= anyHalt;
      clearCount   <= anyClear;
      matchFlag    <= hit;
    end
  end

  // Interrupt level from flags and mask as they stand after this edge; never lags a write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Write to the action register followed by a read of it
  sequence s_action_write;
    regWr && selAction;
  endsequence

  sequence s_action_read;
    regRd && selAction && !regWr;
  endsequence

  a_halt_on_match: assert property (
    (|(hit & haltEn)) |=> haltCounters)
    else $error("halt not raised after enabled match");

  a_halt_only_on_match: assert property (
    haltCounters |-> $past(counterRunEnable) && ($past(action) != ACTION_RST))
    else $error("halt raised without an enabled match");

  a_clear_on_match: assert property (
    ((|(hit & clrEn)) && !(|(hit & haltEn))) |=> clearCount)
    else $error("clear not raised after enabled match");

  a_stop_beats_clear: assert property (
    (|(hit & haltEn)) |=> (haltCounters && !clearCount))
    else $error("clear raised alongside a halt");

  a_irq_flag_set: assert property (
    (hit[0] && irqEn[0] && condOk) |=> status[0] ##0 (irq || !mask[0]))
    else $error("match interrupt flag or line not raised");

  a_irq_cond_gate: assert property (
    (!condOk && !status[1] && !(regWr)) |=> !status[1])
    else $error("flag set while condition select forbids it");

  a_action_readback: assert property (
    s_action_write ##1 !regWr ##1 s_action_read |=>
      (regRdata[ACTION_W-1:0] == $past(regWdata[ACTION_W-1:0], 3)))
    else $error("action bits do not read back");

  a_action_reset: assert property (
    $rose(arst_n) |-> (action == ACTION_RST))
    else $error("action bits not cleared by reset");

  // Write-one-clear aimed at the flag of the last channel
  sequence s_flag_top_clear;
    wrStatus && regWdata[NUM_CH-1];
  endsequence

  a_flag_w1c: assert property (
    s_flag_top_clear ##0 !irqSet[NUM_CH-1] |=> !status[NUM_CH-1])
    else $error("write one did not clear the match flag");

  a_flag_sticky: assert property (
    (status[NUM_CH-1] && !(wrStatus && regWdata[NUM_CH-1])) |=> status[NUM_CH-1])
    else $error("match flag dropped without a clear");

  a_irq_level: assert property (
    irq == |(status & mask))
    else $error("interrupt line disagrees with flags and mask");

  a_stopped_no_action: assert property (
    !counterRunEnable |=> (matchFlag == '0) && !haltCounters && !clearCount)
    else $error("action raised while the counter is stopped");

  a_clear_only_match: assert property (
    clearCount |-> $past(|(hit & clrEn)) && !$past(anyHalt))
    else $error("clear raised without an enabled match");

  a_rdata_idle_zero: assert property (
    !regRd |=> (regRdata == '0))
    else $error("read data not zero outside a read");

endmodule

// file: rtl/tmac_pkg.sv
package tmac_pkg;

  // Widths of the bus and the counter
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned NUM_CH  = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_ACTION = 8'h00;  // Match action bits
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Sticky match interrupt flags, write one to clear
  localparam logic [7:0] OFS_MASK   = 8'h08;  // Interrupt mask, one passes a flag

  // Field layout of the action register: three bits per channel
  localparam int unsigned CH_STRIDE = 3;
  localparam int unsigned IRQ_OFS   = 0;      // Interrupt on match
  localparam int unsigned CLR_OFS   = 1;      // Reset count on match
  localparam int unsigned HALT_OFS  = 2;      // Halt counters on match
  localparam int unsigned ACTION_W  = NUM_CH * CH_STRIDE;

  // Reset values: every action disabled
  localparam logic [ACTION_W-1:0] ACTION_RST = 9'h000;
  localparam logic [NUM_CH-1:0]   FLAG_RST   = 3'h0;

  // Condition select code under which a match raises its interrupt
  localparam logic [2:0] COND_ON_MATCH = 3'h0;

  // Bit index of one action of one channel
  function automatic int unsigned act_bit(input int unsigned ch, input int unsigned ofs);
    act_bit = ch * CH_STRIDE + ofs;
  endfunction

endpackage

// file: sim/tb_timer_match_action_control.sv
`timescale 1ns/100ps

module tb_timer_match_action_control;
  import tmac_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

  logic              mclk, arst_n, regWr, regRd, runEn;     // Clock, reset, strobes
  logic [ADDR_W-1:0] regAddr;                                // Register address
  logic [DATA_W-1:0] regWdata, regRdata;                     // Bus data
  logic [15:0]       countValue;                             // Stand-in running count
  logic [2:0]        condSel, matchFlag;                     // Condition code, flags
  logic              haltCounters, clearCount, irq;          // Action outputs
  int                err_count, n_checks;                    // Tallies

  tmac_match_ctrl uut (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .countValue(countValue), .matchValue0(16'h0010), .matchValue1(16'h0020),
    .matchValue2(16'h0030), .counterRunEnable(runEn), .irqConditionSelect(condSel),
    .haltCounters(haltCounters), .clearCount(clearCount), .matchFlag(matchFlag), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks: one-cycle strobes, changed right after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk); regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge mclk); regWr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk); regRd <= 1'b1; regAddr <= a;
    @(posedge mclk); regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // One-cycle match on a channel; leaves us just after the answering edge
  task automatic hit(input int ch);
    @(posedge mclk); countValue <= 16'(16'h0010 * (ch + 1));
    @(posedge mclk); countValue <= 16'hffff;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenario: reset values, read/write, upper bits and unmapped place
  task automatic reg_access();
    logic [31:0] d;
    rd(OFS_ACTION, d); `CHK(d, 32'h0000_0000)
    rd(OFS_MASK, d);   `CHK(d, 32'h0000_0000)
    rd(OFS_STATUS, d); `CHK(d, 32'h0000_0000)
    @(posedge mclk) #1 `CHK(regRdata, 32'h0)
    wr(OFS_ACTION, 32'hffff_ffff);
    rd(OFS_ACTION, d); `CHK(d, 32'h0000_01ff)
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, d);      `CHK(d, 32'h0000_0000)
    wr(OFS_ACTION, 32'h0);
  endtask

  // Scenario: halt, clear, halt-beats-clear per channel
  task automatic actions(input int ch);
    wr(OFS_ACTION, 32'h4 << (3 * ch));
    hit(ch);
    `CHK(haltCounters, 1'b1)
    `CHK(matchFlag, 3'(1 << ch))
    wr(OFS_ACTION, 32'h2 << (3 * ch));
    hit(ch);
    `CHK({haltCounters, clearCount}, 2'b01)
    wr(OFS_ACTION, 32'h6 << (3 * ch));
    hit(ch);
    `CHK({haltCounters, clearCount}, 2'b10)
    @(posedge mclk) runEn <= 1'b0;                // A stopped core sees no match
    hit(ch);
    `CHK({haltCounters, matchFlag}, 4'h0)
    @(posedge mclk) runEn <= 1'b1;
  endtask

  // Scenario: interrupt raised, masked, suppressed by condition, cleared
  task automatic interrupt(input int ch);
    logic [31:0] d;
    wr(OFS_ACTION, 32'h1 << (3 * ch));
    wr(OFS_MASK, 32'h0);
    hit(ch);
    `CHK(irq, 1'b0)
    rd(OFS_STATUS, d); `CHK(d, 32'(1 << ch))
    wr(OFS_MASK, 32'h7);
    `CHK(irq, 1'b1)
    wr(OFS_STATUS, 32'(1 << ch));                 // Write one clears the flag
    `CHK(irq, 1'b0)
    @(posedge mclk) condSel <= 3'h5;              // Other codes must not qualify
    hit(ch);
    rd(OFS_STATUS, d); `CHK(d, 32'h0)
    @(posedge mclk) condSel <= COND_ON_MATCH;
    wr(OFS_ACTION, 32'h0);
    hit(ch);
    `CHK(irq, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict; the only exit of the run
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard: counts as a mismatch
  initial begin
    #200000;
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWdata = 32'h0;
    countValue = 16'hffff; runEn = 1'b1; condSel = COND_ON_MATCH;
    err_count = 0; n_checks = 0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    reg_access();
    for (int ch = 0; ch < 3; ch++) begin
      actions(ch);
      interrupt(ch);
    end
    results();
  end
endmodule
